// file: rsc_reset_source_controller.v
/*
 reset source controller: merges external pin, address trap, watchdog
 and system clock resets; drives the open-drain reset pin; holds the core
 in reset and clears the reset-cleared state.
 assumes the reset pin is pulled up externally and that fetch strobes,
 watchdog and clock-control inputs come from logic on sys_clk.
*/
`timescale 1ns/1ps
`include "rsc_defs.vh"

module rsc_reset_source_controller (
	// clock and reset
	input  wire                     sys_clk,
	input  wire                     reset,
	// reset pin, open drain
	input  wire                     reset_pin_in,
	output reg                      reset_pin_out,
	output reg                      reset_pin_oe,
	// internal sources
	input  wire                     fetch_valid,
	input  wire [`RSC_ADDR_W-1:0]   fetch_addr,
	input  wire                     watchdog_req,
	input  wire [7:0]               system_control_two,
	// core side
	output reg                      core_reset,
	output reg                      vector_load,
	output reg  [`RSC_ADDR_W-1:0]   vector_addr,
	output reg                      clear_interrupt_enable_flags,
	output reg                      clear_interrupt_latches,
	output reg                      clear_prescaler,
	output reg                      watchdog_enable_force,
	output reg                      malfunction_flag
);

	// state registers
	reg                          pin_meta;
	reg                          pin_sync;
	reg  [`RSC_SYNC_DEPTH-1:0]   oe_hist;
	reg  [`RSC_CNT_W-1:0]        ext_cnt;
	reg                          ext_active;
	reg  [`RSC_CNT_W-1:0]        int_cnt;
	reg                          int_active;
	reg                          core_rst_d;

	// next values
	reg  [`RSC_CNT_W-1:0]        next_ext_cnt;
	reg                          next_ext_active;
	reg  [`RSC_CNT_W-1:0]        next_int_cnt;
	reg                          next_int_active;
	reg                          next_pin_oe;
	reg                          next_core_reset;
	reg                          next_vector_load;
	reg                          next_malfunction;

	// address trap regions and source terms
	wire [`RSC_ADDR_W-1:0]       region_lo [0:`RSC_REGIONS-1];
	wire [`RSC_ADDR_W-1:0]       region_hi [0:`RSC_REGIONS-1];
	wire [`RSC_REGIONS-1:0]      region_hit;
	wire                         trap;
	wire                         clk_stop;
	wire                         int_req;
	wire                         pin_low;
	wire                         echo_mask;
	wire                         ext_pin_low;
	wire                         any_src;

	assign region_lo[`RSC_RGN_SFR]  = `RSC_SFR_LO;
	assign region_hi[`RSC_RGN_SFR]  = `RSC_SFR_HI;
	assign region_lo[`RSC_RGN_RAM]  = `RSC_RAM_LO;
	assign region_hi[`RSC_RGN_RAM]  = `RSC_RAM_HI;
	assign region_lo[`RSC_RGN_BANK] = `RSC_BANK_LO;
	assign region_hi[`RSC_RGN_BANK] = `RSC_BANK_HI;

	genvar gi;
	generate
		for (gi = 0; gi < `RSC_REGIONS; gi = gi + 1) begin : g_region
			assign region_hit[gi] = (fetch_addr >= region_lo[gi]) &&
				(fetch_addr <= region_hi[gi]);
		end
	endgenerate

	assign trap = fetch_valid && (|region_hit);
	assign clk_stop = (system_control_two[`RSC_SYS_CLKSEL_HI:
		`RSC_SYS_CLKSEL_LO] == 3'b000);
	assign int_req = !int_active && !core_reset &&
		(trap || watchdog_req || clk_stop);
	assign pin_low = !pin_sync;
	// the pin reads back our own drive two syncs late; that echo
	// must not pass for an external reset
	assign echo_mask = reset_pin_oe || (|oe_hist);
	assign ext_pin_low = pin_low && !echo_mask;
	assign any_src = ext_active || int_active || pin_low;

	// pin is asynchronous to sys_clk
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
		end else begin
			pin_meta <= reset_pin_in;
			pin_sync <= pin_meta;
		end
	end

	// history of our own pin drive, as deep as the synchroniser
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			oe_hist <= {`RSC_SYNC_DEPTH{1'b0}};
		end else begin
			oe_hist <= {oe_hist[`RSC_SYNC_DEPTH-2:0], reset_pin_oe};
		end
	end

	// external qualification: count while held low from outside
	always @* begin
		next_ext_cnt    = ext_cnt;
		next_ext_active = ext_active;
		if (!ext_pin_low) begin
			next_ext_cnt    = {`RSC_CNT_W{1'b0}};
			next_ext_active = 1'b0;
		end else if (ext_cnt >= `RSC_EXT_MIN_CLKS - 1) begin
			next_ext_active = 1'b1;
		end else begin
			next_ext_cnt = ext_cnt + 1'b1;
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ext_cnt    <= {`RSC_CNT_W{1'b0}};
			ext_active <= 1'b0;
		end else begin
			ext_cnt    <= next_ext_cnt;
			ext_active <= next_ext_active;
		end
	end

	// internal malfunction pulse; the counter is the only timer, so a
	// power-up glitch on the sources still ends inside the bound
	always @* begin
		next_int_cnt    = int_cnt;
		next_int_active = int_active;
		if (int_req) begin
			next_int_cnt    = {`RSC_CNT_W{1'b0}};
			next_int_active = 1'b1;
		end else if (int_active) begin
			if (int_cnt >= `RSC_INT_HOLD_CLKS - 1) begin
				next_int_active = 1'b0;
			end else begin
				next_int_cnt = int_cnt + 1'b1;
			end
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			int_cnt    <= {`RSC_CNT_W{1'b0}};
			int_active <= 1'b0;
		end else begin
			int_cnt    <= next_int_cnt;
			int_active <= next_int_active;
		end
	end

	// pin drive follows the internal pulse only, so int_cnt bounds it
	always @* begin
		next_pin_oe = 1'b0;
		if (int_req) begin
			next_pin_oe = 1'b1;
		end else if (int_active &&
			(int_cnt < `RSC_INT_HOLD_CLKS - 1)) begin
			next_pin_oe = 1'b1;
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reset_pin_oe <= 1'b0;
		end else begin
			reset_pin_oe <= next_pin_oe;
		end
	end

	// open drain: the data side only ever pulls low
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reset_pin_out <= 1'b0;
		end else begin
			reset_pin_out <= 1'b0;
		end
	end

	// core reset holds while any source is active and lets go only
	// on a clock edge
	always @* begin
		next_core_reset  = any_src || int_req;
		next_vector_load = core_rst_d && !core_reset;
		next_malfunction = malfunction_flag;
		if (int_req) begin
			next_malfunction = 1'b1;
		end else if (ext_active) begin
			next_malfunction = 1'b0;
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			core_reset <= 1'b1;
		end else begin
			core_reset <= next_core_reset;
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			core_rst_d  <= 1'b1;
			vector_load <= 1'b0;
		end else begin
			core_rst_d  <= core_reset;
			vector_load <= next_vector_load;
		end
	end

	// restart vector: low byte of the three-byte vector
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			vector_addr <= `RSC_VEC_LO;
		end else begin
			vector_addr <= `RSC_VEC_LO;
		end
	end

	// clearing strobes trail core_reset by one edge
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			clear_interrupt_enable_flags <= 1'b1;
		end else begin
			clear_interrupt_enable_flags <= core_reset;
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			clear_interrupt_latches <= 1'b1;
		end else begin
			clear_interrupt_latches <= core_reset;
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			clear_prescaler <= 1'b1;
		end else begin
			clear_prescaler <= core_reset;
		end
	end

	// watchdog comes back enabled after every reset
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			watchdog_enable_force <= 1'b1;
		end else begin
			watchdog_enable_force <= core_reset;
		end
	end

	// a malfunction record survives until a genuine pin reset
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			malfunction_flag <= 1'b0;
		end else begin
			malfunction_flag <= next_malfunction;
		end
	end

	// general registers, stack pointer, flags and RAM get no clear
	// strobe from this block on purpose

endmodule

// file: rsc_defs.vh
/*
 reset source controller constants: timing counts, vector addresses,
 trap address ranges and clock-control bit positions.
 assumes a 125 MHz sys_clk; included by bare name.
*/
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

`define RSC_CLK_PERIOD_NS    8
`define RSC_CLKS_PER_MCYC    4
`define RSC_EXT_MIN_MCYC     3
`define RSC_EXT_MIN_CLKS     (`RSC_EXT_MIN_MCYC * `RSC_CLKS_PER_MCYC)
`define RSC_INT_MIN_CLKS     8
`define RSC_INT_MAX_CLKS     24
`define RSC_INT_HOLD_CLKS    16
`define RSC_CNT_W            5
`define RSC_VEC_LO           20'hF_FFFC
`define RSC_VEC_MID          20'hF_FFFD
`define RSC_VEC_HI           20'hF_FFFE
`define RSC_ADDR_W           20
`define RSC_RAM_LO           20'h0_0040
`define RSC_RAM_HI           20'h0_063F
`define RSC_BANK_LO          20'h0_0F80
`define RSC_BANK_HI          20'h0_0FFF
`define RSC_SFR_LO           20'h0_0000
`define RSC_SFR_HI           20'h0_003F
`define RSC_SYS_CLKSEL_HI    7
`define RSC_SYS_CLKSEL_LO    5
`define RSC_IEF_W            16
`define RSC_SYNC_DEPTH       2
`define RSC_REGIONS          3
`define RSC_RGN_SFR          0
`define RSC_RGN_RAM          1
`define RSC_RGN_BANK         2
`define RSC_PRESC_W          22

`endif

// file: rsc_monitor.sv
/* port checker for the reset source controller.
 assumes rsc_defs.vh and a pulled-up reset pin. */
`timescale 1ns/1ps
`include "rsc_defs.vh"
module rsc_monitor (
	// pin and sources
	input logic sys_clk, reset, reset_pin_in, reset_pin_oe,
	input logic fetch_valid, watchdog_req,
	input logic [`RSC_ADDR_W-1:0] fetch_addr,
	input logic [7:0] system_control_two,
	// core side
	input logic core_reset, vector_load, clear_prescaler,
	input logic clear_interrupt_latches,
	input logic [`RSC_ADDR_W-1:0] vector_addr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire idle = !core_reset && !reset_pin_oe;
	wire trap = fetch_valid && (fetch_addr <= `RSC_RAM_HI ||
		fetch_addr inside {[`RSC_BANK_LO:`RSC_BANK_HI]});
	sequence s_pulse;
		reset_pin_oe[*8] ##[1:16] !reset_pin_oe;
	endsequence
	a_pulse_width: assert property ($rose(reset_pin_oe) |-> s_pulse)
		else $error("pin pulse length");
	a_trap_fires: assert property (idle && trap |=> reset_pin_oe)
		else $error("no trap reset");
	a_watchdog_fires: assert property (idle && watchdog_req |=> core_reset)
		else $error("no watchdog reset");
	a_clock_stop: assert property (
		idle && system_control_two[7:5] == 3'h0 |=> reset_pin_oe)
		else $error("no clock reset");
	a_pin_applies: assert property (
		$fell(reset_pin_in) |-> ##[1:3] core_reset)
		else $error("pin low ignored");
	a_oe_in_reset: assert property (reset_pin_oe |-> core_reset)
		else $error("pin driven outside reset");
	a_hold_sources: assert property (
		$fell(core_reset) |-> $past(reset_pin_in, 2) && !reset_pin_oe)
		else $error("early");
	a_vector_start: assert property (
		$fell(core_reset) |-> ##1 vector_load
		&& vector_addr == `RSC_VEC_LO) else $error("bad restart");
	a_clear_state: assert property (
		core_reset |=> clear_prescaler && clear_interrupt_latches)
		else $error("state not cleared");
endmodule
bind rsc_reset_source_controller rsc_monitor u_mon (.sys_clk, .reset,
	.reset_pin_in, .reset_pin_oe, .fetch_valid, .watchdog_req, .fetch_addr,
	.system_control_two, .core_reset, .vector_load, .clear_prescaler,
	.clear_interrupt_latches, .vector_addr);

// file: rsc_board.sv
/* board side of the reset pin: pull-up plus a supervisor holding
 the pin low for a commanded count. assumes sys_clk from the bench. */
`timescale 1ns/1ps
module rsc_board (
	input logic sys_clk, start, reset_pin_oe,
	input logic [7:0] len,
	output logic reset_pin_in
);
	logic [7:0] left = 8'h00;
	// pull-up wins unless either party pulls low
	assign reset_pin_in = !(reset_pin_oe || left != 8'h00);
	always @(posedge sys_clk)
		left <= start ? len : left - {7'h00, left != 8'h00};
endmodule

// file: tb_top.sv
/* table-driven bench for the reset source controller.
 assumes rsc_defs.vh and the board model on the reset pin. */
`timescale 1ns/1ps
`include "rsc_defs.vh"
module tb_top;
	logic sys_clk = 0, reset = 1, fetch_valid = 0, watchdog_req = 0;
	logic start = 0, reset_pin_in, reset_pin_out, reset_pin_oe;
	logic [`RSC_ADDR_W-1:0] fetch_addr = 0, vector_addr;
	logic [7:0] system_control_two = 8'hE0, len = 8'h0C;
	logic core_reset, vector_load, clear_interrupt_enable_flags;
	logic clear_interrupt_latches, clear_prescaler, watchdog_enable_force;
	logic malfunction_flag;
	int miscompares = 0, checked = 0, n;
	// expect, watchdog, clock control, fetch strobe, address
	logic [39:0] rows [10] = '{40'h10_E010_0000, 40'h10_E010_063F,
		40'h00_E010_0640, 40'h10_E010_0F80, 40'h00_E010_0F7F,
		40'h10_E010_0FFF, 40'h00_E010_1000, 40'h11_E000_8000,
		40'h10_1F00_8000, 40'h00_2000_8000};
	rsc_reset_source_controller u_rsc_reset_source_controller (.*);
	rsc_board u_rsc_board (.sys_clk(sys_clk), .start(start), .len(len),
		.reset_pin_oe(reset_pin_oe), .reset_pin_in(reset_pin_in));
	initial forever #4 sys_clk = !sys_clk;
	task automatic chk(input logic [19:0] got, exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// bounded so a reset that never lets go shows up as a mismatch
	task automatic restart;
		for (n = 0; n < 80 && vector_load !== 1'b1; n++)
			@(posedge sys_clk) #1;
		chk(vector_load, 1);
		chk(vector_addr, `RSC_VEC_LO);
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		chk(core_reset, 1);
		reset <= 0;
		restart();
		foreach (rows[i]) begin
			repeat (3) @(posedge sys_clk);
			fetch_valid <= rows[i][20];
			fetch_addr <= rows[i][19:0];
			watchdog_req <= rows[i][32];
			system_control_two <= rows[i][31:24];
			@(posedge sys_clk);
			fetch_valid <= 0;
			watchdog_req <= 0;
			system_control_two <= 8'hE0;
			#1 chk(reset_pin_oe, rows[i][36]);
			if (rows[i][36])
				restart();
		end
		chk(malfunction_flag, 1);
		start <= 1;
		@(posedge sys_clk);
		start <= 0;
		repeat (4) @(posedge sys_clk);
		watchdog_req <= 1;
		@(posedge sys_clk);
		watchdog_req <= 0;
		#1 chk(core_reset, 1);
		chk(reset_pin_oe, 0);
		restart();
		chk(malfunction_flag, 0);
		reset <= 1;
		@(posedge sys_clk) #1 chk(core_reset, 1);
		chk(clear_interrupt_enable_flags, 1);
		chk(watchdog_enable_force, 1);
		chk(reset_pin_out, 0);
		reset <= 0;
		restart();
		chk(clear_interrupt_enable_flags, 0);
		chk(watchdog_enable_force, 0);
		conclude();
	end
	initial begin
		#100000;
		miscompares++;
		conclude();
	end
endmodule
